// ===== shared/meas_enc_pkg.sv
// shared constants and types for the measurement output encoder
package meas_enc_pkg;
  // clock
  localparam int unsigned CLK_MHZ = 200;
  // distance coding without mastering (16 bit) and with mastering (18 bit)
  localparam logic [15:0] RANGE_START = 16'h0283;
  localparam logic [15:0] RANGE_END = 16'hfd77;
  localparam logic [15:0] RESERVE_END = 16'hfff0;
  localparam logic [15:0] RANGE_SPAN_MASTERED = 16'hfaeb;
  localparam logic [17:0] MASTER_CODE_MAX = 18'h3ffba;
  // replacement distance codes
  localparam logic [17:0] DIST_OVERFLOW = 18'h3ffbb;
  localparam logic [17:0] DIST_NO_PEAK = 18'h3ffbc;
  localparam logic [17:0] DIST_BEFORE = 18'h3ffbd;
  localparam logic [17:0] DIST_BEHIND = 18'h3ffbe;
  localparam logic [17:0] DIST_NO_CALC = 18'h3ffc0;
  localparam logic [17:0] DIST_TOO_LARGE = 18'h3ffc1;
  localparam logic [17:0] DIST_LASER_OFF = 18'h3ffc2;
  localparam logic [15:0] INTENSITY_MAX = 16'hffc0;
  // status word bit positions
  localparam int unsigned ST_PEAK_BEFORE = 0;
  localparam int unsigned ST_PEAK_AFTER = 1;
  localparam int unsigned ST_NO_PEAK = 2;
  localparam int unsigned ST_BEFORE_RANGE = 5;
  localparam int unsigned ST_AFTER_RANGE = 6;
  localparam int unsigned ST_TRIGGERED = 15;
  localparam int unsigned ST_LAMP_LO = 16;
  // status lamp codes
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_GREEN = 2'h1;
  localparam logic [1:0] LAMP_RED = 2'h2;
  localparam logic [1:0] LAMP_YELLOW = 2'h3;
  // output word order
  localparam logic [2:0] W_DIST = 3'h0;
  localparam logic [2:0] W_EXPO = 3'h1;
  localparam logic [2:0] W_INTENS = 3'h2;
  localparam logic [2:0] W_STATUS = 3'h3;
  localparam logic [2:0] W_TS_LO = 3'h4;
  localparam logic [2:0] W_TS_HI = 3'h5;
  localparam logic [2:0] W_FOCUS = 3'h6;
  // current output in microamps
  localparam logic [15:0] UA_ERROR = 16'h0bb8;
  localparam logic [15:0] UA_ZERO = 16'h0fa0;
  localparam logic [15:0] UA_SPAN = 16'h3e80;
  localparam logic [15:0] UA_MIN = 16'h0ed8;
  localparam logic [15:0] UA_MAX = 16'h4ee8;
  // register word addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SELECT = 4'h1;
  localparam logic [3:0] REG_REFERENCE = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_TEACH_LO = 4'h4;
  localparam logic [3:0] REG_TEACH_HI = 4'h5;
  localparam logic [3:0] REG_LAST_DIST = 4'h6;
  localparam logic [3:0] REG_TIME = 4'h7;
  localparam int unsigned CTRL_MASTER_EN = 0;
  localparam int unsigned CTRL_TEACH = 1;
  localparam int unsigned CTRL_MASTER_SET = 2;
  localparam int unsigned CTRL_SCALE_RESET = 3;
  localparam logic [6:0] SELECT_RESET = 7'h7f;
  localparam logic [17:0] REFERENCE_RESET = 18'h00000;
  // times
  localparam int unsigned KEY_HOLD_MS = 10000;
  localparam int unsigned RESET_WINDOW_MS = 5000;
  localparam int unsigned BLINK_MS = 2000;
  localparam int unsigned BLINK_HZ = 8;
  localparam int unsigned TS_TICK_NS = 10000;
  localparam int unsigned TS_TICK_CYC = (TS_TICK_NS * CLK_MHZ) / 1000;
  typedef enum logic [1:0] {T_IDLE, T_WAIT2, T_RST_WAIT, T_RST_HELD} teach_state_t;
endpackage

// ===== design/meas_output_encoder.sv
// measurement word encoder with teach sequencer and status lamp
//
// Function
// - every selected quantity leaves as an unsigned 16 or 18 bit word
// - unmastered distance is 16 bit, range 643..64887, reserves around it
// - mastered distance is 18 bit, shifted by the reference value
// - reference value spans up to twice the range; mastered results use 18 bits
// - exposure period is 18 bit in tenths of a microsecond
// - intensity is 16 bit, 0..65472
// - status word carries peak, reserve and trigger flags at fixed bits
// - status bits 17:16 mirror the lamp colour
// - time stamp goes out as low then high 16 bit word, 10 us per count
// - focus position is an 18 bit word
// - overflow, no peak, peak before range replace the distance code
// - peak behind, no value, peak too large, laser off replace it too
// - taught scaling affects only current and switching output
// - a teach aborts when no valid measurement exists
// - teach requests come from select key, multifunction input or software
// - scaling reset key misuse blinks the lamp red at 8 Hz for 2 s
// - a multifunction input pulse starts analog scaling
// - with user scaling the switching output works as a limit switch
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module meas_output_encoder #(
  parameter int unsigned KEY_HOLD_CYC = meas_enc_pkg::KEY_HOLD_MS * (meas_enc_pkg::CLK_MHZ * 1000),
  parameter int unsigned RST_WIN_CYC = meas_enc_pkg::RESET_WINDOW_MS * (meas_enc_pkg::CLK_MHZ * 1000),
  parameter int unsigned BLINK_CYC = meas_enc_pkg::BLINK_MS * (meas_enc_pkg::CLK_MHZ * 1000),
  parameter int unsigned BLINK_HALF_CYC = (meas_enc_pkg::CLK_MHZ * 1000000) / (2 * meas_enc_pkg::BLINK_HZ)
) (
  input wire logic clock, // system clock
  input wire logic arst_n, // async reset
  input wire logic [3:0] reg_addr, // register word address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic meas_valid, // new measurement pulse
  input wire logic [15:0] meas_raw, // raw position code
  input wire logic peak_before_win, // peak starts before evaluation_window
  input wire logic peak_after_win, // peak ends after evaluation_window
  input wire logic no_peak, // no peak found
  input wire logic peak_too_large, // peak too large
  input wire logic no_calc, // value not computable
  input wire logic before_range, // peak before range_start reserve
  input wire logic behind_range, // peak beyond range_end reserve
  input wire logic laser_off, // laser switched off
  input wire logic triggered, // value was triggered
  input wire logic [17:0] exposure_period, // exposure, 0.1 us steps
  input wire logic [15:0] intensity, // intensity code
  input wire logic [17:0] focus_raw, // focus position
  input wire logic select_key, // front select key, high = pressed
  input wire logic multifunction_in, // multifunction hardware input
  output logic out_valid, // word valid
  input wire logic out_ready, // word taken
  output logic [17:0] out_data, // word data
  output logic [2:0] out_index, // which quantity
  output logic out_wide, // 18 bit word when high
  output logic [15:0] analog_ua, // current output in uA
  output logic switch_out, // switching output
  output logic [1:0] lamp // status lamp colour
);
  import meas_enc_pkg::*;

  // ******************************
  // measurement capture
  // ******************************
  logic busy_r, ovf_pend_r, master_en_r, scale_active_r, blink_active_r, phase_r;
  logic [2:0] idx_r;
  logic [6:0] sel_r;
  logic [17:0] ref_r, mpos_r;
  logic [17:0] words_r [7];
  logic [15:0] last_raw_r;
  logic last_ok_r, last_err_r, last_off_r;
  logic [31:0] ts_r;
  logic [1:0] lamp_r;
  logic take, meas_err, advance;
  logic [17:0] dist_code;
  logic signed [19:0] mastered;

  assign take = meas_valid & ~busy_r;
  assign meas_err = no_peak | peak_too_large | no_calc | before_range | behind_range | laser_off;
  assign mastered = $signed({4'h0, meas_raw}) - $signed({2'h0, mpos_r}) + $signed({2'h0, ref_r});

  // error codes win over the measured value; laser off first
  always_comb begin
    if (laser_off) begin
      dist_code = DIST_LASER_OFF;
    end else if (ovf_pend_r) begin
      dist_code = DIST_OVERFLOW;
    end else if (no_peak) begin
      dist_code = DIST_NO_PEAK;
    end else if (peak_too_large) begin
      dist_code = DIST_TOO_LARGE;
    end else if (no_calc) begin
      dist_code = DIST_NO_CALC;
    end else if (before_range) begin
      dist_code = DIST_BEFORE;
    end else if (behind_range) begin
      dist_code = DIST_BEHIND;
    end else if (!master_en_r) begin
      dist_code = {2'h0, meas_raw};
    end else if (mastered < 0) begin
      dist_code = 18'h00000;
    end else if (mastered > $signed({2'h0, MASTER_CODE_MAX})) begin
      dist_code = MASTER_CODE_MAX;
    end else begin
      dist_code = mastered[17:0];
    end
  end

  // overflow: a measurement arriving while the previous one is still going out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovf_pend_r <= 1'b0;
    end else if (meas_valid && busy_r) begin
      ovf_pend_r <= 1'b1;
    end else if (take) begin
      ovf_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 7; i++) begin
        words_r[i] <= 18'h00000;
      end
      last_raw_r <= 16'h0000;
      last_ok_r <= 1'b0;
      last_err_r <= 1'b0;
      last_off_r <= 1'b0;
    end else if (take) begin
      words_r[W_DIST] <= dist_code;
      words_r[W_EXPO] <= exposure_period;
      words_r[W_INTENS] <= {2'h0, intensity};
      words_r[W_STATUS] <= {lamp_r, triggered, 8'h00, behind_range | (meas_raw > RESERVE_END),
                            before_range, 2'h0, no_peak, peak_after_win, peak_before_win};
      words_r[W_TS_LO] <= {2'h0, ts_r[15:0]};
      words_r[W_TS_HI] <= {2'h0, ts_r[31:16]};
      words_r[W_FOCUS] <= focus_raw;
      last_raw_r <= meas_raw;
      last_ok_r <= ~meas_err;
      last_err_r <= meas_err;
      last_off_r <= laser_off;
    end
  end

  // ******************************
  // time stamp, 10 us per count
  // ******************************
  logic [11:0] tick_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_r <= 12'h000;
      ts_r <= 32'h00000000;
    end else if (tick_r == 12'(TS_TICK_CYC - 1)) begin
      tick_r <= 12'h000;
      ts_r <= ts_r + 32'h00000001;
    end else begin
      tick_r <= tick_r + 12'h001;
    end
  end

  // ******************************
  // word stream
  // ******************************
  // unselected words are skipped silently, one cycle each, so spacing is fixed
  assign advance = busy_r & (~sel_r[idx_r] | out_ready);
  assign out_valid = busy_r & sel_r[idx_r];
  assign out_data = words_r[idx_r];
  assign out_index = idx_r;
  assign out_wide = (idx_r == W_DIST) ? master_en_r : ~(idx_r == W_INTENS || idx_r == W_TS_LO || idx_r == W_TS_HI);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      idx_r <= 3'h0;
    end else if (take) begin
      busy_r <= 1'b1;
      idx_r <= 3'h0;
    end else if (advance) begin
      busy_r <= (idx_r != W_FOCUS);
      idx_r <= (idx_r == W_FOCUS) ? 3'h0 : idx_r + 3'h1;
    end
  end

  // ******************************
  // teach sequencer
  // ******************************
  teach_state_t state_r;
  logic key_d_r, mf_d_r, key_rise, key_fall, mf_rise, web_teach, req, teach_abort, teach_done, blink_start;
  logic [15:0] p1_r, lo_r, hi_r;
  logic [31:0] timer_r;
  logic wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign web_teach = wr_ctrl & reg_wdata[CTRL_TEACH];
  assign key_rise = select_key & ~key_d_r;
  assign key_fall = ~select_key & key_d_r;
  assign mf_rise = multifunction_in & ~mf_d_r;
  assign req = key_rise | mf_rise | web_teach;
  assign teach_abort = req & ((state_r == T_IDLE) & ~last_ok_r |
                              (state_r == T_WAIT2) & (~last_ok_r | (last_raw_r == p1_r)));
  assign teach_done = req & (state_r == T_WAIT2) & last_ok_r & (last_raw_r != p1_r);
  assign blink_start = ((state_r == T_RST_WAIT) & ~key_rise & (timer_r >= RST_WIN_CYC - 1)) |
                       ((state_r == T_RST_HELD) & ~key_fall & (timer_r >= KEY_HOLD_CYC - 1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      key_d_r <= 1'b0;
      mf_d_r <= 1'b0;
    end else begin
      key_d_r <= select_key;
      mf_d_r <= multifunction_in;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= T_IDLE;
      timer_r <= 32'h00000000;
      p1_r <= 16'h0000;
    end else begin
      timer_r <= timer_r + 32'h00000001;
      unique case (state_r)
        T_IDLE: begin
          if (wr_ctrl && reg_wdata[CTRL_SCALE_RESET]) begin
            state_r <= T_RST_WAIT;
            timer_r <= 32'h00000000;
          end else if (req && last_ok_r) begin
            state_r <= T_WAIT2;
            p1_r <= last_raw_r;
          end
        end
        T_WAIT2: begin
          if (req) begin
            state_r <= T_IDLE;
          end
        end
        T_RST_WAIT: begin
          if (key_rise) begin
            state_r <= T_RST_HELD;
            timer_r <= 32'h00000000;
          end else if (blink_start) begin
            state_r <= T_IDLE;
          end
        end
        T_RST_HELD: begin
          if (key_fall || blink_start) begin
            state_r <= T_IDLE;
          end
        end
      endcase
    end
  end

  // previous scaling survives until a second point completes or the key is released in T_RST_HELD
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scale_active_r <= 1'b0;
      lo_r <= RANGE_START;
      hi_r <= RANGE_END;
    end else if (teach_done) begin
      scale_active_r <= 1'b1;
      lo_r <= p1_r;
      hi_r <= last_raw_r;
    end else if (state_r == T_RST_HELD && key_fall) begin
      scale_active_r <= 1'b0;
      lo_r <= RANGE_START;
      hi_r <= RANGE_END;
    end
  end

  // ******************************
  // lamp and error blink
  // ******************************
  logic [31:0] blink_cnt_r, half_cnt_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      blink_active_r <= 1'b0;
      blink_cnt_r <= 32'h00000000;
      half_cnt_r <= 32'h00000000;
      phase_r <= 1'b0;
    end else if (blink_start) begin
      blink_active_r <= 1'b1;
      blink_cnt_r <= 32'h00000000;
      half_cnt_r <= 32'h00000000;
      phase_r <= 1'b1;
    end else if (blink_active_r) begin
      blink_cnt_r <= blink_cnt_r + 32'h00000001;
      blink_active_r <= (blink_cnt_r != BLINK_CYC - 1);
      half_cnt_r <= (half_cnt_r == BLINK_HALF_CYC - 1) ? 32'h00000000 : half_cnt_r + 32'h00000001;
      phase_r <= (half_cnt_r == BLINK_HALF_CYC - 1) ? ~phase_r : phase_r;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lamp_r <= LAMP_OFF;
    end else if (blink_active_r) begin
      lamp_r <= phase_r ? LAMP_RED : LAMP_OFF;
    end else if (last_off_r) begin
      lamp_r <= LAMP_OFF;
    end else if (last_err_r) begin
      lamp_r <= LAMP_RED;
    end else if (last_raw_r < RANGE_START || last_raw_r > RANGE_END) begin
      lamp_r <= LAMP_YELLOW;
    end else begin
      lamp_r <= LAMP_GREEN;
    end
  end
  assign lamp = lamp_r;

  // ******************************
  // current and switching output
  // ******************************
  logic signed [39:0] pos_s, lo_s, hi_s, ua_s;
  logic [15:0] analog_r;
  logic switch_r;
  always_comb begin
    pos_s = $signed({24'h000000, last_raw_r});
    lo_s = $signed({24'h000000, lo_r});
    hi_s = $signed({24'h000000, hi_r});
    ua_s = $signed({24'h000000, UA_ZERO}) + ((pos_s - lo_s) * $signed({24'h000000, UA_SPAN})) / (hi_s - lo_s);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      analog_r <= UA_ERROR;
      switch_r <= 1'b0;
    end else begin
      if (last_err_r) begin
        analog_r <= UA_ERROR;
      end else if (ua_s < $signed({24'h000000, UA_MIN})) begin
        analog_r <= UA_MIN;
      end else if (ua_s > $signed({24'h000000, UA_MAX})) begin
        analog_r <= UA_MAX;
      end else begin
        analog_r <= ua_s[15:0];
      end
      if (scale_active_r) begin
        switch_r <= (last_raw_r < ((lo_r < hi_r) ? lo_r : hi_r)) |
                    (last_raw_r > ((lo_r < hi_r) ? hi_r : lo_r));
      end else begin
        switch_r <= last_err_r;
      end
    end
  end
  assign analog_ua = analog_r;
  assign switch_out = switch_r;

  // ******************************
  // register port
  // ******************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      master_en_r <= 1'b0;
      sel_r <= SELECT_RESET;
      ref_r <= REFERENCE_RESET;
      mpos_r <= 18'h00000;
      reg_rdata <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        master_en_r <= reg_wdata[CTRL_MASTER_EN];
        if (reg_wdata[CTRL_MASTER_SET]) begin
          mpos_r <= {2'h0, last_raw_r};
        end
      end
      if (reg_wr && reg_addr == REG_SELECT) begin
        sel_r <= reg_wdata[6:0];
      end
      if (reg_wr && reg_addr == REG_REFERENCE) begin
        ref_r <= reg_wdata[17:0];
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          REG_CTRL: reg_rdata <= {31'h00000000, master_en_r};
          REG_SELECT: reg_rdata <= {25'h0000000, sel_r};
          REG_REFERENCE: reg_rdata <= {14'h0000, ref_r};
          REG_STATUS: reg_rdata <= {25'h0000000, ovf_pend_r, blink_active_r, scale_active_r, state_r, lamp_r};
          REG_TEACH_LO: reg_rdata <= {16'h0000, lo_r};
          REG_TEACH_HI: reg_rdata <= {16'h0000, hi_r};
          REG_LAST_DIST: reg_rdata <= {14'h0000, words_r[W_DIST]};
          REG_TIME: reg_rdata <= ts_r;
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ******************************
  // assertions
  // ******************************
  sequence s_take_ok;
    take && !meas_err && !ovf_pend_r && !master_en_r;
  endsequence
  sequence s_mf_teach;
    mf_rise && state_r == T_IDLE && last_ok_r && !wr_ctrl;
  endsequence

  property p_lamp_mirror;
    @(posedge clock) disable iff (!arst_n) take |=> words_r[W_STATUS][17:16] == $past(lamp_r);
  endproperty
  a_lamp_mirror: assert property (p_lamp_mirror) else $error("status lamp bits mismatch");
  property p_overflow;
    @(posedge clock) disable iff (!arst_n) ovf_pend_r && take && !laser_off
      |=> words_r[W_DIST] == DIST_OVERFLOW;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow code missing");
  property p_laser_off;
    @(posedge clock) disable iff (!arst_n) take && laser_off |=> words_r[W_DIST] == DIST_LASER_OFF;
  endproperty
  a_laser_off: assert property (p_laser_off) else $error("laser off code missing");
  property p_plain_dist;
    @(posedge clock) disable iff (!arst_n) s_take_ok |=> words_r[W_DIST] == {2'h0, $past(meas_raw)} && busy_r;
  endproperty
  a_plain_dist: assert property (p_plain_dist) else $error("unmastered distance wrong");
  property p_error_current;
    @(posedge clock) disable iff (!arst_n) take && meas_err |=> ##1 analog_ua == UA_ERROR;
  endproperty
  a_error_current: assert property (p_error_current) else $error("error current not driven");
  property p_abort_keeps;
    @(posedge clock) disable iff (!arst_n) teach_abort |=> lo_r == $past(lo_r) && hi_r == $past(hi_r)
      && scale_active_r == $past(scale_active_r);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("scaling changed on abort");
  property p_blink;
    @(posedge clock) disable iff (!arst_n) blink_start |=> blink_active_r [*8] ##0 lamp != LAMP_GREEN;
  endproperty
  a_blink: assert property (p_blink) else $error("error blink too short");
  property p_mf_teach;
    @(posedge clock) disable iff (!arst_n) s_mf_teach |=> state_r == T_WAIT2 && p1_r == $past(last_raw_r);
  endproperty
  a_mf_teach: assert property (p_mf_teach) else $error("multifunction pulse ignored");
  property p_stream_len;
    @(posedge clock) disable iff (!arst_n) take && sel_r == 7'h00 |=> busy_r [*7] ##1 !busy_r;
  endproperty
  a_stream_len: assert property (p_stream_len) else $error("word walk length wrong");
endmodule
`default_nettype wire

// ===== verification/meas_host_model.sv
// host model that takes measurement words, with optional stalling
`timescale 1ns/1ps
`default_nettype none
module meas_host_model (
  input wire logic clock, // system clock
  input wire logic arst_n, // async reset
  input wire logic stall, // take only every other cycle
  input wire logic meas_valid, // clears done flag
  input wire logic out_valid, // word valid
  input wire logic [17:0] out_data, // word data
  input wire logic [2:0] out_index, // word index
  output logic out_ready, // word taken
  output logic done, // last word of a set taken
  output logic [17:0] got [7] // last word seen per index
);
  // ****************
  // take and record
  // ****************
  logic ph_r;
  // a slow host is no kinder: ready is dropped every other cycle
  assign out_ready = !stall || ph_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= 1'b0;
      done <= 1'b0;
    end else begin
      ph_r <= !ph_r;
      if (meas_valid) begin
        done <= 1'b0;
      end else if (out_valid && out_ready && out_index == 3'h6) begin
        done <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (out_valid && out_ready && out_index < 3'h7) begin
      got[out_index] <= out_data;
    end
  end
endmodule
`default_nettype wire

// ===== verification/measurement_output_encoder_test.sv
// register and stream tests of the measurement output encoder
`timescale 1ns/1ps
`default_nettype none
module measurement_output_encoder_test;
  import meas_enc_pkg::*;
  // ****************
  // stimulus and host
  // ****************
  logic clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, meas_valid = 1'b0, out_ready, done;
  logic select_key = 1'b0, multifunction_in = 1'b0, stall = 1'b0, out_valid, out_wide, switch_out;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [15:0] meas_raw = 16'h0, analog_ua;
  logic [8:0] flg = 9'h0;
  logic [17:0] out_data, got [7];
  logic [17:0] expo = 18'h3ffff, focus = 18'h2aaaa;
  logic [15:0] intens = INTENSITY_MAX;
  logic [2:0] out_index;
  logic [1:0] lamp;
  logic [17:0] ecode [6] = '{DIST_NO_PEAK, DIST_TOO_LARGE, DIST_NO_CALC, DIST_BEFORE, DIST_BEHIND, DIST_LASER_OFF};
  int n_errors = 0, compares = 0, cyc = 0, k;
  always #2.5 clock = !clock;
  meas_output_encoder #(.KEY_HOLD_CYC(40), .RST_WIN_CYC(30), .BLINK_CYC(64), .BLINK_HALF_CYC(4))
  i_meas_output_encoder (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas_raw(meas_raw),
    .peak_before_win(flg[0]), .peak_after_win(flg[1]), .no_peak(flg[2]), .peak_too_large(flg[3]),
    .no_calc(flg[4]), .before_range(flg[5]), .behind_range(flg[6]), .laser_off(flg[7]), .triggered(flg[8]),
    .exposure_period(expo), .intensity(intens), .focus_raw(focus), .select_key(select_key),
    .multifunction_in(multifunction_in), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_index(out_index), .out_wide(out_wide), .analog_ua(analog_ua), .switch_out(switch_out), .lamp(lamp));
  meas_host_model i_meas_host_model (.clock(clock), .arst_n(arst_n), .stall(stall), .meas_valid(meas_valid),
    .out_valid(out_valid), .out_data(out_data), .out_index(out_index), .out_ready(out_ready), .done(done),
    .got(got));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // one measurement; drop adds a second pulse while busy, which must be lost
  task automatic meas(input logic [15:0] raw, input logic [8:0] f, input bit drop);
    @(posedge clock);
    meas_valid <= 1'b1; meas_raw <= raw; flg <= f;
    @(posedge clock);
    meas_valid <= 1'b0;
    if (drop) begin
      @(posedge clock); meas_valid <= 1'b1;
      @(posedge clock); meas_valid <= 1'b0;
    end
    // let the host clear its done flag before it is polled
    #1;
    for (k = 0; k < 100 && done !== 1'b1; k++) begin
      @(posedge clock); #1;
    end
    chk("done", 1, done);
  endtask
  task automatic pulse(input bit mf);
    @(posedge clock);
    if (mf) multifunction_in <= 1'b1; else select_key <= 1'b1;
    repeat (3) @(posedge clock);
    multifunction_in <= 1'b0; select_key <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    chk("analog reset", UA_ERROR, analog_ua);
    rd(REG_SELECT, d); chk("select", SELECT_RESET, d);
    rd(REG_TEACH_LO, d); chk("teach lo", 643, d);
    rd(REG_TEACH_HI, d); chk("teach hi", 64887, d);
    rd(4'h9, d); chk("unmapped", 0, d);
    $display("test reset done");
    stall <= 1'b1;
    meas(16'd1000, 9'h103, 0);
    chk("dist", 1000, got[W_DIST]);
    chk("expo", 18'h3ffff, got[W_EXPO]);
    chk("intens", INTENSITY_MAX, got[W_INTENS]);
    chk("status", 16'h8003, got[W_STATUS][15:0]);
    chk("status lamp", LAMP_YELLOW, got[W_STATUS][17:16]);
    chk("focus", 18'h2aaaa, got[W_FOCUS]);
    meas(16'd1000, 9'h0, 1);
    meas(16'd1000, 9'h0, 0); chk("overflow", DIST_OVERFLOW, got[W_DIST]);
    for (int i = 0; i < 6; i++) begin
      meas(16'd1000, 9'h4 << i, 0);
      chk("err code", ecode[i], got[W_DIST]);
      chk("err analog", UA_ERROR, analog_ua);
    end
    stall <= 1'b0;
    $display("test stream done");
    wr(REG_CTRL, 32'h2);
    rd(REG_TEACH_LO, d); chk("abort lo", 643, d);
    meas(16'd2000, 9'h0, 0); pulse(1);
    meas(16'd2000, 9'h0, 0); wr(REG_CTRL, 32'h2);
    rd(REG_TEACH_LO, d); chk("same lo", 643, d);
    rd(REG_STATUS, d); chk("teach idle", 0, d[3:2]);
    meas(16'd2000, 9'h0, 0); pulse(0);
    meas(16'd10000, 9'h0, 0); wr(REG_CTRL, 32'h2);
    rd(REG_TEACH_LO, d); chk("taught lo", 2000, d);
    rd(REG_TEACH_HI, d); chk("taught hi", 10000, d);
    meas(16'd6000, 9'h0, 0);
    chk("scaled ua", 12000, analog_ua);
    chk("serial kept", 6000, got[W_DIST]);
    meas(16'd12000, 9'h0, 0); chk("limit", 1, switch_out);
    $display("test teach done");
    // master position is captured from the last raw code, 12000 here
    wr(REG_REFERENCE, 32'd11000); wr(REG_CTRL, 32'h5);
    #1 chk("wide dist", 1, out_wide);
    @(posedge clock);
    expo <= 18'h00001;
    intens <= 16'h0000;
    focus <= 18'h3ffff;
    meas(16'd7000, 9'h0, 0);
    chk("mastered", 6000, got[W_DIST]);
    chk("expo min", 1, got[W_EXPO]);
    chk("intens min", 0, got[W_INTENS]);
    chk("focus max", 18'h3ffff, got[W_FOCUS]);
    wr(REG_CTRL, 32'h0);
    #1 chk("narrow dist", 0, out_wide);
    $display("test master done");
    wr(REG_CTRL, 32'h8); pulse(0);
    rd(REG_TEACH_LO, d); chk("unscaled lo", 643, d);
    rd(REG_STATUS, d); chk("unscaled", 0, d[4]);
    wr(REG_SELECT, 32'h0);
    @(posedge clock);
    meas_valid <= 1'b1;
    meas_raw <= 16'd3000;
    flg <= 9'h0;
    @(posedge clock);
    meas_valid <= 1'b0;
    #1 chk("unselected", 0, out_valid);
    repeat (9) @(posedge clock);
    rd(REG_LAST_DIST, d); chk("skip dist", 3000, d);
    wr(REG_SELECT, 32'h7f);
    $display("test select done");
    wr(REG_CTRL, 32'h8);
    for (k = 0; k < 80 && lamp !== LAMP_RED; k++) begin
      @(posedge clock); #1;
    end
    chk("blink red", LAMP_RED, lamp);
    rd(REG_STATUS, d); chk("blink on", 1, d[5]);
    repeat (90) @(posedge clock);
    rd(REG_STATUS, d); chk("blink off", 0, d[5]);
    $display("test blink done");
    complete_run;
  end
endmodule
`default_nettype wire
